// >>> verilog/nppf_pkg.sv
// Constants and types for the page program target state machine
package nppf_pkg;
	localparam int            NPPF_ADDR_CYCLES = 5;
	localparam int            NPPF_COL_CYCLES  = 2;
	localparam int            NPPF_LUN_BITS    = 2;
	localparam int            NPPF_LUN_COUNT   = 4;
	localparam int            NPPF_PLANE_BITS  = 2;
	localparam int            NPPF_LUN_POS     = 22;
	localparam int            NPPF_PLANE_POS   = 0;
	localparam logic [2:0]    NPPF_ACNT_RST    = 3'h0;
	localparam logic [7:0]    NPPF_CMD_SETUP   = 8'h80;
	localparam logic [7:0]    NPPF_CMD_CONFIRM = 8'h10;
	localparam logic [7:0]    NPPF_CMD_MPLANE  = 8'h11;
	localparam logic [7:0]    NPPF_CMD_CACHE   = 8'h15;
	localparam logic [7:0]    NPPF_CMD_COLCHG  = 8'h85;
	localparam logic [7:0]    NPPF_LASTCMD_RST = 8'h00;
	localparam logic [39:0]   NPPF_ADDR_RST    = 40'h0000_0000_00;
	localparam logic [15:0]   NPPF_DATA_RST    = 16'h0000;
	localparam logic [NPPF_LUN_BITS-1:0] NPPF_LUN_RST = 2'h0;

	typedef enum logic [3:0] {
		NPPF_IDLE        = 4'b0000,
		NPPF_PROG_ENTRY  = 4'b0001,
		NPPF_CB_ENTRY    = 4'b0010,
		NPPF_ADDR_WAIT   = 4'b0011,
		NPPF_ADDR_CAP    = 4'b0100,
		NPPF_UNIT_ISSUE  = 4'b0101,
		NPPF_DATA_WAIT   = 4'b0110,
		NPPF_DATA_FWD    = 4'b0111,
		NPPF_CONF_FWD    = 4'b1000,
		NPPF_MPL_WAIT    = 4'b1001,
		NPPF_COL_CHANGE  = 4'b1010
	} nppf_state_t;
endpackage : nppf_pkg

// >>> verilog/nppf_addr_cap.sv
// Address cycle collector for the program sequence
`timescale 1ns/10ps
module nppf_addr_cap
	import nppf_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clear,
	input  wire logic        store,
	input  wire logic [7:0]  addr_byte,
	output logic             done,
	output logic [39:0]      addr
);
	logic [2:0]  cnt_r;
	logic [2:0]  cnt_nxt;
	logic [39:0] addr_r;
	logic [39:0] addr_nxt;
	wire         last_cycle = (cnt_r == 3'(NPPF_ADDR_CYCLES - 1));

	assign cnt_nxt  = clear ? NPPF_ACNT_RST : (store ? cnt_r + 3'h1 : cnt_r);
	assign addr_nxt = addr_r | (40'(addr_byte) << {cnt_r, 3'h0});
	assign done     = last_cycle;
	assign addr     = addr_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r  <= NPPF_ACNT_RST;
			addr_r <= NPPF_ADDR_RST;
		end else begin
			cnt_r <= cnt_nxt;
			if (clear)
				addr_r <= NPPF_ADDR_RST;
			else if (store)
				addr_r <= addr_nxt;
		end
	end
endmodule : nppf_addr_cap

// >>> verilog/nppf_target.sv
// Target state machine for page program and cache program sequences
`timescale 1ns/10ps
module nppf_target
	import nppf_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      prog_start,
	input  wire logic                      copyback_start,
	input  wire logic                      copyback_flag,
	input  wire logic                      clear_enh_enable,
	input  wire logic                      ready_busy_out,
	input  wire logic                      status_flag_clear,
	input  wire logic                      cmd_valid,
	input  wire logic [7:0]                cmd_byte,
	input  wire logic                      addr_valid,
	input  wire logic [7:0]                addr_byte,
	input  wire logic                      data_valid,
	input  wire logic [15:0]               data_word,
	output logic [7:0]                     last_command_var,
	output logic                           status_enh_required_flag,
	output logic [NPPF_LUN_BITS-1:0]       selected_lun,
	output logic [NPPF_LUN_COUNT-1:0]      lun_clear_all,
	output logic                           lun_clear_plane,
	output logic [NPPF_PLANE_BITS-1:0]     lun_clear_plane_addr,
	output logic                           lun_prog_issue,
	output logic [39:0]                    lun_prog_addr,
	output logic                           lun_data_valid,
	output logic [15:0]                    lun_data,
	output logic                           lun_cmd_valid,
	output logic [7:0]                     lun_cmd,
	output logic [3:0]                     state_out
);
	nppf_state_t                  state_r;
	nppf_state_t                  state_nxt;
	logic [7:0]                   last_cmd_r;
	logic                         stat_req_r;
	logic [NPPF_LUN_BITS-1:0]     lun_r;
	logic [NPPF_LUN_COUNT-1:0]    clr_all_r;
	logic                         clr_plane_r;
	logic [NPPF_PLANE_BITS-1:0]   clr_plane_addr_r;
	logic                         issue_r;
	logic [39:0]                  issue_addr_r;
	logic                         dval_r;
	logic [15:0]                  data_r;
	logic [15:0]                  data_hold_r;
	logic                         cval_r;
	logic [7:0]                   cmd_r;
	logic [7:0]                   cmd_hold_r;
	logic                         addr_done;
	logic [39:0]                  addr_full;

	// Command code match, shared by the data wait decode and the confirm routing
	function automatic logic nppf_cmd_is(input logic [7:0] code, input logic [7:0] op);
		return (code == op);
	endfunction : nppf_cmd_is

	wire in_prog    = (state_r == NPPF_PROG_ENTRY);
	wire in_cb      = (state_r == NPPF_CB_ENTRY);
	wire in_addr    = (state_r == NPPF_ADDR_CAP);
	wire in_issue   = (state_r == NPPF_UNIT_ISSUE);
	wire in_dwait   = (state_r == NPPF_DATA_WAIT);
	wire in_conf    = (state_r == NPPF_CONF_FWD);
	wire in_dfwd    = (state_r == NPPF_DATA_FWD);
	wire busy_low   = ~ready_busy_out;
	wire stat_set   = (in_prog | in_cb) & busy_low;
	wire is_conf    = nppf_cmd_is(cmd_byte, NPPF_CMD_CONFIRM) | nppf_cmd_is(cmd_byte, NPPF_CMD_MPLANE);
	wire is_cache   = nppf_cmd_is(cmd_byte, NPPF_CMD_CACHE) & ~copyback_flag;
	wire is_colchg  = nppf_cmd_is(cmd_byte, NPPF_CMD_COLCHG);
	wire held_mpl   = nppf_cmd_is(cmd_hold_r, NPPF_CMD_MPLANE);
	wire [NPPF_LUN_BITS-1:0]   row_lun   = addr_full[NPPF_LUN_POS +: NPPF_LUN_BITS];
	wire [NPPF_PLANE_BITS-1:0] row_plane = addr_full[NPPF_PLANE_POS + 8*NPPF_COL_CYCLES +: NPPF_PLANE_BITS];
	wire addr_clear = in_prog | in_cb;
	wire addr_store = in_addr;

	nppf_addr_cap u_addr (
		.clk       (clk),
		.rst       (rst),
		.clear     (addr_clear),
		.store     (addr_store),
		.addr_byte (cmd_hold_r),
		.done      (addr_done),
		.addr      (addr_full)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			NPPF_IDLE: begin
				if (prog_start)
					state_nxt = NPPF_PROG_ENTRY;
				else if (copyback_start)
					state_nxt = NPPF_CB_ENTRY;
			end
			NPPF_PROG_ENTRY: state_nxt = NPPF_ADDR_WAIT;
			NPPF_CB_ENTRY:   state_nxt = NPPF_ADDR_WAIT;
			NPPF_ADDR_WAIT: begin
				if (addr_valid)
					state_nxt = NPPF_ADDR_CAP;
			end
			NPPF_ADDR_CAP: begin
				if (addr_done)
					state_nxt = NPPF_UNIT_ISSUE;
				else
					state_nxt = NPPF_ADDR_WAIT;
			end
			NPPF_UNIT_ISSUE: state_nxt = NPPF_DATA_WAIT;
			NPPF_DATA_WAIT: begin
				if (data_valid)
					state_nxt = NPPF_DATA_FWD;
				else if (cmd_valid & (is_conf | is_cache))
					state_nxt = NPPF_CONF_FWD;
				else if (cmd_valid & is_colchg)
					state_nxt = NPPF_COL_CHANGE;
			end
			NPPF_DATA_FWD: state_nxt = NPPF_DATA_WAIT;
			NPPF_CONF_FWD: begin
				if (held_mpl)
					state_nxt = NPPF_MPL_WAIT;
				else
					state_nxt = NPPF_IDLE;
			end
			NPPF_MPL_WAIT:   state_nxt = NPPF_MPL_WAIT;
			NPPF_COL_CHANGE: state_nxt = NPPF_COL_CHANGE;
			default:         state_nxt = NPPF_IDLE;
		endcase
		if (prog_start & (state_r == NPPF_MPL_WAIT | state_r == NPPF_COL_CHANGE))
			state_nxt = NPPF_PROG_ENTRY;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r    <= NPPF_IDLE;
			last_cmd_r <= NPPF_LASTCMD_RST;
			stat_req_r <= 1'b0;
			cmd_hold_r <= NPPF_LASTCMD_RST;
			data_hold_r <= NPPF_DATA_RST;
		end else begin
			state_r <= state_nxt;
			if (in_prog)
				last_cmd_r <= NPPF_CMD_SETUP;
			if (stat_set)
				stat_req_r <= 1'b1;
			else if (status_flag_clear)
				stat_req_r <= 1'b0;
			if (addr_valid & (state_r == NPPF_ADDR_WAIT))
				cmd_hold_r <= addr_byte;
			else if (cmd_valid & in_dwait)
				cmd_hold_r <= cmd_byte;
			if (data_valid & in_dwait)
				data_hold_r <= data_word;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lun_r            <= NPPF_LUN_RST;
			clr_all_r        <= '0;
			clr_plane_r      <= 1'b0;
			clr_plane_addr_r <= '0;
			issue_r          <= 1'b0;
			issue_addr_r     <= NPPF_ADDR_RST;
			dval_r           <= 1'b0;
			data_r           <= NPPF_DATA_RST;
			cval_r           <= 1'b0;
			cmd_r            <= NPPF_LASTCMD_RST;
		end else begin
			clr_all_r   <= {NPPF_LUN_COUNT{in_prog & ~clear_enh_enable}};
			clr_plane_r <= in_issue & clear_enh_enable;
			issue_r     <= in_issue;
			dval_r      <= in_dfwd;
			cval_r      <= in_conf;
			if (in_issue) begin
				lun_r            <= row_lun;
				clr_plane_addr_r <= row_plane;
				issue_addr_r     <= addr_full;
			end
			if (in_dfwd)
				data_r <= data_hold_r;
			if (in_conf)
				cmd_r <= cmd_hold_r;
		end
	end

	assign last_command_var         = last_cmd_r;
	assign status_enh_required_flag = stat_req_r;
	assign selected_lun             = lun_r;
	assign lun_clear_all            = clr_all_r;
	assign lun_clear_plane          = clr_plane_r;
	assign lun_clear_plane_addr     = clr_plane_addr_r;
	assign lun_prog_issue           = issue_r;
	assign lun_prog_addr            = issue_addr_r;
	assign lun_data_valid           = dval_r;
	assign lun_data                 = data_r;
	assign lun_cmd_valid            = cval_r;
	assign lun_cmd                  = cmd_r;
	assign state_out                = state_r;
endmodule : nppf_target

// >>> dv/nppf_target_monitor.sv
// Checker of state flow and unit requests
`timescale 1ns/10ps
module nppf_target_monitor (
	input logic        clk,
	input logic        rst,
	input logic        copyback_flag,
	input logic        clear_enh_enable,
	input logic        ready_busy_out,
	input logic        cmd_valid,
	input logic [7:0]  cmd_byte,
	input logic        addr_valid,
	input logic        data_valid,
	input logic [15:0] data_word,
	input logic [7:0]  last_command_var,
	input logic        status_enh_required_flag,
	input logic [1:0]  selected_lun,
	input logic [3:0]  lun_clear_all,
	input logic        lun_clear_plane,
	input logic [1:0]  lun_clear_plane_addr,
	input logic        lun_prog_issue,
	input logic [39:0] lun_prog_addr,
	input logic        lun_data_valid,
	input logic [15:0] lun_data,
	input logic        lun_cmd_valid,
	input logic [7:0]  lun_cmd,
	input logic [3:0]  state_out
);
	wire       cmd_ok = cmd_valid && !data_valid && cmd_byte inside {8'h10, 8'h11, 8'h15, 8'h85};
	wire [3:0] route_nxt = cmd_byte == 8'h85 ? 4'hA : (cmd_byte == 8'h15 && copyback_flag) ? 4'h6 : 4'h8;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_entry_cmd: assert property (state_out == 4'h1 |=> last_command_var == 8'h80 && state_out == 4'h3)
		else $error("entry step wrong");
	a_busy_flag: assert property ((state_out == 4'h1 || state_out == 4'h2) && !ready_busy_out |=>
		status_enh_required_flag && state_out == 4'h3) else $error("busy flag not set");
	a_clear_all: assert property (state_out == 4'h1 |=> lun_clear_all == (clear_enh_enable ? 4'h0 : 4'hF))
		else $error("clear all wrong");
	a_addr_step: assert property (state_out == 4'h3 && addr_valid |=> state_out == 4'h4 ##1
		(state_out == 4'h3 || state_out == 4'h5)) else $error("address step wrong");
	a_unit_issue: assert property (state_out == 4'h5 |=> state_out == 4'h6 && lun_prog_issue &&
		selected_lun == lun_prog_addr[23:22]) else $error("issue wrong");
	a_plane_clr: assert property (state_out == 4'h5 && clear_enh_enable |-> ##[1:2]
		(lun_clear_plane && lun_clear_plane_addr == lun_prog_addr[17:16])) else $error("plane clear");
	a_data_fwd: assert property (state_out == 4'h6 && data_valid |=> state_out == 4'h7 ##1
		(lun_data_valid && lun_data == $past(data_word, 2) && state_out == 4'h6)) else $error("data");
	a_cmd_route: assert property (state_out == 4'h6 && cmd_ok |=> state_out == $past(route_nxt))
		else $error("command route wrong");
	a_conf_pass: assert property (state_out == 4'h8 |=> lun_cmd_valid && lun_cmd == $past(cmd_byte, 2) &&
		state_out == (lun_cmd == 8'h11 ? 4'h9 : 4'h0)) else $error("confirm pass wrong");
	c_mpl: cover property (state_out == 4'h9);
	c_col: cover property (state_out == 4'hA);
	c_cache: cover property (lun_cmd_valid && lun_cmd == 8'h15);
endmodule : nppf_target_monitor
bind nppf_target nppf_target_monitor u_mon (.*);

// >>> dv/nppf_host_model.sv
// Host controller model issuing command, address and data cycles
`timescale 1ns/10ps
module nppf_host_model (
	input  logic        clk,
	input  logic [3:0]  state_out,
	output logic        prog_start,
	output logic        cmd_valid,
	output logic [7:0]  cmd_byte,
	output logic        addr_valid,
	output logic [7:0]  addr_byte,
	output logic        data_valid,
	output logic [15:0] data_word
);
	initial begin
		{prog_start, cmd_valid, addr_valid, data_valid} = 4'h0;
		{cmd_byte, addr_byte, data_word} = 32'h0000_0000;
	end
	// Waits for the state, pulses one cycle, then scrambles released lines
	task automatic send(input logic [1:0] k, input logic [3:0] st, input logic [15:0] v);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (state_out !== st && n < 60);
		@(posedge clk);
		case (k)
			2'h0: prog_start <= 1'b1;
			2'h1: {addr_valid, addr_byte} <= {1'b1, v[7:0]};
			2'h2: {data_valid, data_word} <= {1'b1, v};
			default: {cmd_valid, cmd_byte} <= {1'b1, v[7:0]};
		endcase
		@(posedge clk);
		{prog_start, cmd_valid, addr_valid, data_valid} <= 4'h0;
		{cmd_byte, addr_byte, data_word} <= ~{cmd_byte, addr_byte, data_word};
	endtask : send
endmodule : nppf_host_model

// >>> dv/nppf_target_test.sv
// Self-checking bench for the program target
`timescale 1ns/10ps
module nppf_target_test;
	logic clk = 1'b0, rst = 1'b1, copyback_start = 1'b0, copyback_flag = 1'b0;
	logic clear_enh_enable = 1'b0, ready_busy_out = 1'b1, status_flag_clear = 1'b0;
	logic prog_start, cmd_valid, addr_valid, data_valid, status_enh_required_flag, lun_clear_plane;
	logic lun_prog_issue, lun_data_valid, lun_cmd_valid;
	logic [7:0] cmd_byte, addr_byte, last_command_var, lun_cmd;
	logic [15:0] data_word, lun_data;
	logic [1:0] selected_lun, lun_clear_plane_addr;
	logic [3:0] lun_clear_all, state_out;
	logic [39:0] lun_prog_addr;
	int miscompares = 0, num_checks = 0, cycles = 0;
	always #5 clk = ~clk;
	nppf_host_model host (.*);
	nppf_target dut (.*);
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step
	// Setup when go is set, five address cycles, two data words
	task automatic run_seq(input logic go, input logic [3:0] st0, input logic [7:0] a2);
		if (go) host.send(2'h0, st0, 16'h0000);
		for (int i = 0; i < 5; i++) host.send(2'h1, 4'h3, (i == 2) ? {8'h00, a2} : 16'h0010 + i[15:0]);
		host.send(2'h2, 4'h6, 16'hA5C3);
		host.send(2'h2, 4'h6, 16'h5A3C);
	endtask : run_seq
	task automatic s_program();
		@(posedge clk);
		ready_busy_out <= 1'b0;
		run_seq(1'b1, 4'h0, 8'hC1);
		host.send(2'h3, 4'h6, 16'h0010);
		step();
		chk(state_out, 4'h0);
		chk(lun_cmd, 8'h10);
		chk(last_command_var, 8'h80);
		chk(status_enh_required_flag, 1'b1);
		chk(selected_lun, 2'h3);
		chk(lun_prog_addr, 40'h14_13C1_1110);
		chk(lun_data, 16'h5A3C);
	endtask : s_program
	task automatic s_multi();
		@(posedge clk);
		{ready_busy_out, clear_enh_enable, status_flag_clear} <= 3'h7;
		@(posedge clk);
		status_flag_clear <= 1'b0;
		run_seq(1'b1, 4'h0, 8'h42);
		host.send(2'h3, 4'h6, 16'h0011);
		step();
		chk(state_out, 4'h9);
		chk(status_enh_required_flag, 1'b0);
		chk(lun_clear_plane_addr, 2'h2);
		run_seq(1'b1, 4'h9, 8'h42);
		host.send(2'h3, 4'h6, 16'h0015);
		step();
		chk(state_out, 4'h0);
		chk(lun_cmd, 8'h15);
	endtask : s_multi
	task automatic s_copyback();
		@(posedge clk);
		{ready_busy_out, clear_enh_enable, copyback_flag, copyback_start} <= 4'h3;
		@(posedge clk);
		copyback_start <= 1'b0;
		run_seq(1'b0, 4'h0, 8'h80);
		host.send(2'h3, 4'h6, 16'h0015);
		step();
		chk(state_out, 4'h6);
		host.send(2'h3, 4'h6, 16'h0085);
		step();
		chk(state_out, 4'hA);
		chk(status_enh_required_flag, 1'b1);
		chk(selected_lun, 2'h2);
	endtask : s_copyback
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		s_program();
		s_multi();
		s_copyback();
		tally_and_finish();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			tally_and_finish();
		end
	end
endmodule : nppf_target_test
